// ===== hw/slwsp_sram_port.sv
// Late-write SRAM port: command pipe, memory array and write buffer.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Write buffer
module slwsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0]   wr_ptr;
  logic [PTR_W:0]   rd_ptr;
  wire              push  = in_valid_i & in_ready_o;
  wire              pop   = out_valid_o & out_ready_i;
  // The extra pointer bit tells a full buffer from an empty one when
  // both pointers name the same slot.
  wire              wrapped   = (wr_ptr[PTR_W] != rd_ptr[PTR_W]);
  wire              same_slot = (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
  wire              empty     = ~wrapped & same_slot;
  wire              full      = wrapped & same_slot;

  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = store[rd_ptr[PTR_W-1:0]];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) store[wr_ptr[PTR_W-1:0]] <= in_data_i;
  end
endmodule : slwsp_fifo

// ==========================================
// Port top
module slwsp_sram_port #(
  parameter bit WIDE_ORG = 1'b1,
  parameter int DATA_W   = WIDE_ORG ? slwsp_pkg::DATA_W_X36
                                    : slwsp_pkg::DATA_W_X18,
  parameter int ADDR_W   = WIDE_ORG ? slwsp_pkg::ADDR_W_X36
                                    : slwsp_pkg::ADDR_W_X18,
  parameter int LANES    = DATA_W / slwsp_pkg::LANE_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clock_enable_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              burst_advance_i,
  input  wire logic              write_n_i,
  input  wire logic [LANES-1:0]  byte_lane_write_n_i,
  input  wire logic              chip_select_first_n_i,
  input  wire logic              chip_select_second_i,
  input  wire logic              chip_select_third_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              sleep_request_i,
  input  wire logic              burst_order_select_i,
  input  wire logic              flow_through_select_i,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_o,
  output logic                   write_buffer_ready_o,
  output logic                   sleep_active_o
);
  localparam int LW = slwsp_pkg::LANE_W;
  localparam int BW = slwsp_pkg::BURST_W;
  localparam int AX = slwsp_pkg::ADDR_W_X18;
  localparam int DX = slwsp_pkg::DATA_W_X36;
  localparam int LX = slwsp_pkg::MAX_LANES;

  // ==========================================
  // Strap and sleep synchronisers
  logic [1:0] strap_meta;
  logic [1:0] strap;
  logic       sleep_meta;
  logic       sleep_sync;

  // Both straps are meant to be tied off; a change is seen two edges
  // later and leaves any access already in the pipe undefined.
  // static straps, synced
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_meta <= slwsp_pkg::STRAP_RST;
      strap      <= slwsp_pkg::STRAP_RST;
      sleep_meta <= slwsp_pkg::SLEEP_RST;
      sleep_sync <= slwsp_pkg::SLEEP_RST;
    end else begin
      strap_meta <= {burst_order_select_i, flow_through_select_i};
      strap      <= strap_meta;
      sleep_meta <= sleep_request_i;
      sleep_sync <= sleep_meta;
    end
  end

  wire interleave = strap[1];
  wire flow_mode  = strap[0];

  // ==========================================
  // Command decode
  slwsp_pkg::slwsp_cmd_t st1;
  slwsp_pkg::slwsp_cmd_t st2;
  slwsp_pkg::slwsp_cmd_t new_cmd;
  slwsp_pkg::slwsp_op_t  burst_op;
  logic [ADDR_W-1:0]     burst_base;
  logic [BW-1:0]         burst_step;

  wire advance = ~clock_enable_n_i;
  wire first_on  = ~chip_select_first_n_i;
  wire second_on = chip_select_second_i;
  wire third_on  = ~chip_select_third_n_i;
  wire selected  = first_on & second_on & third_on;
  // Sleep reaches the decode through two flip-flops, so a command may
  // still be taken on the two edges after the request rises.
  // sleep turns commands into deselects
  wire awake = ~sleep_sync;
  wire cont  = awake & burst_advance_i &
               (burst_op != slwsp_pkg::SLWSP_IDLE);
  wire load  = awake & ~burst_advance_i & selected;

  // The counter restarts at every load; an advance that follows an idle
  // cycle has no burst to continue and stays idle.
  // two-bit counter steps on advance
  wire [BW-1:0] next_step = cont ? burst_step + 1'b1
                                 : slwsp_pkg::BURST_STEP_RST;
  wire [BW-1:0] burst_lsb = interleave ?
                            (burst_base[BW-1:0] ^ next_step) :
                            (burst_base[BW-1:0] + next_step);
  wire [ADDR_W-1:0] cont_addr = {burst_base[ADDR_W-1:BW], burst_lsb};
  wire [ADDR_W-1:0] next_addr = cont ? cont_addr : addr_i;

  // write strobe low selects a write
  wire slwsp_pkg::slwsp_op_t load_op =
    write_n_i ? slwsp_pkg::SLWSP_READ : slwsp_pkg::SLWSP_WRITE;
  wire slwsp_pkg::slwsp_op_t next_op =
    cont ? burst_op : (load ? load_op : slwsp_pkg::SLWSP_IDLE);
  // Lane enables travel with the command on every beat, not with the data.
  // each lane enable is low-active
  wire [LX-1:0] next_lanes = LX'(~byte_lane_write_n_i);

  assign new_cmd = '{op: next_op,
                     addr: AX'(next_addr),
                     lane_en: next_lanes};

  wire [ADDR_W-1:0] next_base = load ? addr_i : burst_base;
  wire slwsp_pkg::slwsp_op_t next_burst_op =
    (cont | load) ? next_op : slwsp_pkg::SLWSP_IDLE;

  // commands taken on rising edge only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st1        <= '0;
      st2        <= '0;
      burst_op   <= slwsp_pkg::SLWSP_IDLE;
      burst_base <= '0;
      burst_step <= slwsp_pkg::BURST_STEP_RST;
    end else if (advance) begin
      st1        <= new_cmd;
      st2        <= st1;
      burst_op   <= next_burst_op;
      burst_base <= next_base;
      burst_step <= next_step;
    end
  end

  // ==========================================
  // Memory array
  // depth follows the organisation
  // The array is not reset; a word is undefined until first written.
  localparam int DEPTH = 1 << ADDR_W;
  logic [DATA_W-1:0] mem [DEPTH];
  // A read that follows a write to the same word too closely sees the
  // old contents, because that write may still sit in the buffer.
  wire  [DATA_W-1:0] rd_word = mem[st1.addr[ADDR_W-1:0]];

  // ==========================================
  // Read path
  logic [DATA_W-1:0] rd1;
  logic [DATA_W-1:0] rd2;
  logic [1:0]        rd_valid;
  wire               st1_rd = (st1.op == slwsp_pkg::SLWSP_READ);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd1      <= '0;
      rd2      <= '0;
      rd_valid <= slwsp_pkg::RD_VALID_RST;
    end else if (advance) begin
      rd1      <= rd_word;
      rd2      <= rd1;
      rd_valid <= {rd_valid[0], st1_rd};
    end
  end

  wire rd_drive = flow_mode ? rd_valid[0] : rd_valid[1];
  assign dq_o   = flow_mode ? rd1 : rd2;
  // output enable and sleep act without clock
  // output enable overrides read control
  // The gate uses the raw pins, not the synchronised sleep, so the
  // drivers turn off at once, at the cost of a path from pin to pin.
  wire   oe_gate = ~output_enable_n_i & ~sleep_request_i;
  assign dq_oe_o = rd_drive & oe_gate;
  assign sleep_active_o = sleep_sync;

  // ==========================================
  // Late write capture
  // data taken one or two cycles later
  slwsp_pkg::slwsp_cmd_t wr_cmd;
  assign wr_cmd = flow_mode ? st1 : st2;
  // A write whose data slot comes while the buffer is full is lost; the
  // ready output lets the controller see that before it happens.
  // a write may follow a read directly
  wire wr_push = advance &
                 (wr_cmd.op == slwsp_pkg::SLWSP_WRITE);

  slwsp_pkg::slwsp_wr_t wr_in;
  slwsp_pkg::slwsp_wr_t wr_out;
  assign wr_in = '{addr: wr_cmd.addr,
                   data: DX'(dq_i),
                   lane_en: wr_cmd.lane_en};

  logic                            wr_valid;
  logic [slwsp_pkg::WR_ENTRY_W-1:0] wr_out_bits;
  assign wr_out = wr_out_bits;

  // The buffer decouples the self-timed array write
  // from the bus; it drains every cycle unless asleep.
  // It drains on gated edges too, since the array write is self-timed.
  slwsp_fifo #(
    .WIDTH (slwsp_pkg::WR_ENTRY_W),
    .DEPTH (slwsp_pkg::WBUF_DEPTH),
    .PTR_W (slwsp_pkg::WBUF_PTR_W)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (write_buffer_ready_o),
    .in_data_i   (wr_in),
    .out_valid_o (wr_valid),
    .out_ready_i (awake),
    .out_data_o  (wr_out_bits)
  );

  // array write needs no external pulse
  wire              wr_commit = wr_valid & awake;
  wire [LX-1:0]     wr_lanes  = wr_out.lane_en;
  wire [ADDR_W-1:0] wr_addr   = wr_out.addr[ADDR_W-1:0];

  always_ff @(posedge clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_commit && wr_lanes[l])
        mem[wr_addr][l*LW +: LW] <=
          wr_out.data[l*LW +: LW];
    end
  end
endmodule : slwsp_sram_port
`default_nettype wire

// ===== pkg/slwsp_pkg.sv
// Shared constants and types of the late-write SRAM port.
`default_nettype none
package slwsp_pkg;
  // ==========================================
  // Organisation and sizes
  localparam int DATA_W_X36 = 36;
  localparam int DATA_W_X18 = 18;
  localparam int ADDR_W_X36 = 17;
  localparam int ADDR_W_X18 = 18;
  localparam int LANE_W     = 9;
  localparam int MAX_LANES  = 4;
  localparam int BURST_W    = 2;
  localparam int WBUF_DEPTH = 8;
  localparam int WBUF_PTR_W = 3;
  // ==========================================
  // Values after reset
  localparam logic [1:0] BURST_STEP_RST = 2'h0;
  localparam logic [1:0] STRAP_RST      = 2'h0;
  localparam logic       SLEEP_RST      = 1'h1;
  localparam logic [1:0] RD_VALID_RST   = 2'h0;
  // ==========================================
  // Commands as they travel down the pipe, and write buffer entries
  typedef enum logic [1:0] {
    SLWSP_IDLE,
    SLWSP_READ,
    SLWSP_WRITE
  } slwsp_op_t;

  typedef struct packed {
    slwsp_op_t                op;
    logic [ADDR_W_X18-1:0]    addr;
    logic [MAX_LANES-1:0]     lane_en;
  } slwsp_cmd_t;

  typedef struct packed {
    logic [ADDR_W_X18-1:0]    addr;
    logic [DATA_W_X36-1:0]    data;
    logic [MAX_LANES-1:0]     lane_en;
  } slwsp_wr_t;

  localparam int WR_ENTRY_W = $bits(slwsp_wr_t);
endpackage : slwsp_pkg
`default_nettype wire

// ===== tb/slwsp_ctrl_model.sv
// Controller-side model that drives write data in the late-write slot.
`timescale 1ns/10ps
`default_nettype none
module slwsp_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clock_enable_n_i,
  input  wire logic        flow_i,
  input  wire logic        wr_i,
  input  wire logic [35:0] wdata_i,
  output logic      [35:0] dq_o
);
  logic [1:0]  v;
  logic [35:0] d0, d1, last;
  wire         drive = flow_i ? v[0] : v[1];
  wire  [35:0] dsel  = flow_i ? d0 : d1;
  // data slot.
  // A released bus shows the inverse of its last word, so a late sample cannot match.
  assign dq_o = drive ? dsel : ~last;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      v    <= 2'h0;
      d0   <= 36'h0_0000_0000;
      d1   <= 36'h0_0000_0000;
      last <= 36'h0_0000_0000;
    end else if (!clock_enable_n_i) begin
      v    <= {v[0], wr_i};
      d0   <= wdata_i;
      d1   <= d0;
      last <= drive ? dsel : last;
    end
  end
endmodule : slwsp_ctrl_model
`default_nettype wire

// ===== tb/slwsp_port_assertions.sv
// Pin-level checks on the late-write SRAM port.
`timescale 1ns/10ps
`default_nettype none
module slwsp_port_checker #(
  parameter int DATA_W = 36
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              clock_enable_n_i,
  input wire logic              burst_advance_i,
  input wire logic              write_n_i,
  input wire logic              chip_select_first_n_i,
  input wire logic              chip_select_second_i,
  input wire logic              chip_select_third_n_i,
  input wire logic              output_enable_n_i,
  input wire logic              sleep_request_i,
  input wire logic              flow_through_select_i,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe_o,
  input wire logic              write_buffer_ready_o,
  input wire logic              sleep_active_o
);
  // ==========================================
  // Sequences
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire sel_all = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
  wire may_out = !output_enable_n_i && !sleep_request_i;
  sequence taken;
    !clock_enable_n_i && !sleep_active_o;
  endsequence
  sequence rd_load;
    taken ##0 (sel_all && !burst_advance_i && write_n_i);
  endsequence
  sequence quiet;
    !clock_enable_n_i && !sel_all && !burst_advance_i;
  endsequence
  // ==========================================
  // Assertions
  a_oe_forces_off: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("drive seen with output enable off");
  a_sleep_forces_off: assert property (sleep_request_i |-> !dq_oe_o)
    else $error("drive seen during sleep request");
  a_sleep_enter: assert property (sleep_request_i ##1 sleep_request_i |=> sleep_active_o)
    else $error("sleep not entered");
  a_sleep_leave: assert property (!sleep_request_i [*3] |=> !sleep_active_o)
    else $error("sleep not left");
  a_freeze_hold: assert property (clock_enable_n_i |=> $stable(dq_o))
    else $error("read data moved on a gated edge");
  a_pipe_latency: assert property (
    rd_load ##0 (!flow_through_select_i && !$past(flow_through_select_i, 2)) ##1 taken ##1 taken
    |=> (!may_out || dq_oe_o)) else $error("pipelined read not driven");
  a_flow_latency: assert property (
    rd_load ##0 (flow_through_select_i && $past(flow_through_select_i, 2)) ##1 taken
    |=> (!may_out || dq_oe_o)) else $error("flow-through read not driven");
  a_deselect_quiet: assert property (quiet ##1 quiet ##1 quiet |=> !dq_oe_o)
    else $error("drive seen while deselected");
  a_buffer_keeps_up: assert property (!sleep_active_o |-> write_buffer_ready_o)
    else $error("write buffer full while awake");
endmodule : slwsp_port_checker
bind slwsp_sram_port slwsp_port_checker #(.DATA_W(DATA_W)) chk_i (
  .clk_i                 (clk_i),
  .rst_n_i               (rst_n_i),
  .clock_enable_n_i      (clock_enable_n_i),
  .burst_advance_i       (burst_advance_i),
  .write_n_i             (write_n_i),
  .chip_select_first_n_i (chip_select_first_n_i),
  .chip_select_second_i  (chip_select_second_i),
  .chip_select_third_n_i (chip_select_third_n_i),
  .output_enable_n_i     (output_enable_n_i),
  .sleep_request_i       (sleep_request_i),
  .flow_through_select_i (flow_through_select_i),
  .dq_o                  (dq_o),
  .dq_oe_o               (dq_oe_o),
  .write_buffer_ready_o  (write_buffer_ready_o),
  .sleep_active_o        (sleep_active_o)
);
`default_nettype wire

// ===== tb/slwsp_sram_port_tb_top.sv
// Directed bench for the late-write SRAM port.
`timescale 1ns/10ps
`default_nettype none
module slwsp_sram_port_tb_top;
  logic clk_i = 0, rst_n_i = 0, clock_enable_n_i = 0, burst_advance_i = 0, write_n_i = 1, wr = 0;
  logic chip_select_first_n_i = 1, chip_select_second_i = 1, chip_select_third_n_i = 0;
  logic output_enable_n_i = 0, sleep_request_i = 0, burst_order_select_i = 0, flow_through_select_i = 0;
  logic [3:0]  byte_lane_write_n_i = 4'hf;
  logic [16:0] addr_i = 17'h0_0000, b;
  logic [35:0] dq_i, dq_o, ed, wd = 36'h0_0000_0000;
  logic        dq_oe_o, write_buffer_ready_o, sleep_active_o, hit;
  int          cnt = 0, lat = 2, fail_count = 0, check_count = 0;
  int          due_q[$];
  logic [35:0] dat_q[$];
  logic [35:0] mem [int];
  slwsp_sram_port #(.WIDE_ORG(1'b1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_enable_n_i(clock_enable_n_i),
    .addr_i(addr_i), .burst_advance_i(burst_advance_i), .write_n_i(write_n_i),
    .byte_lane_write_n_i(byte_lane_write_n_i), .chip_select_first_n_i(chip_select_first_n_i),
    .chip_select_second_i(chip_select_second_i), .chip_select_third_n_i(chip_select_third_n_i),
    .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
    .burst_order_select_i(burst_order_select_i), .flow_through_select_i(flow_through_select_i),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .write_buffer_ready_o(write_buffer_ready_o),
    .sleep_active_o(sleep_active_o));
  slwsp_ctrl_model partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_enable_n_i(clock_enable_n_i),
    .flow_i(flow_through_select_i), .wr_i(wr), .wdata_i(wd), .dq_o(dq_i));
  always #4 clk_i = ~clk_i;
  // ==========================================
  // Tasks
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cmd(input logic wn, burst_advance, input logic [3:0] ln, input logic [16:0] a,
                     input logic [35:0] d, input bit ex);
    chip_select_first_n_i = 0;
    write_n_i = wn;
    burst_advance_i = burst_advance;
    byte_lane_write_n_i = ~ln;
    addr_i = a;
    wr = ex && !wn;
    wd = d;
    if (ex && !wn) for (int i = 0; i < 4; i++) if (ln[i]) mem[a][9*i +: 9] = d[9*i +: 9];
    if (ex && wn) due_q.push_back(cnt + 1 + lat);
    if (ex && wn) dat_q.push_back(mem[a]);
    @(negedge clk_i);
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) begin
      chip_select_first_n_i = 1;
      burst_advance_i = 0;
      wr = 0;
      @(negedge clk_i);
    end
  endtask : idle
  function automatic logic [16:0] ba(input logic [16:0] x, input logic [1:0] s, input logic o);
    ba = x;
    ba[1:0] = o ? x[1:0] ^ s : x[1:0] + s;
  endfunction : ba
  // ==========================================
  // Output monitor and timeout
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 1000) begin
      fail_count++;
      wrap_up();
    end
  end
  // Outputs are looked at 1 ns after the edge, once they have settled.
  always @(posedge clk_i) begin
    #1;
    if (rst_n_i) begin
      hit = due_q.size() != 0 && due_q[0] == cnt;
      ed = hit ? dat_q[0] : 36'h0_0000_0000;
      if (hit) due_q.delete(0);
      if (hit) dat_q.delete(0);
      chk(dq_oe_o, hit && !output_enable_n_i && !sleep_request_i);
      if (dq_oe_o === 1'b1) chk(dq_o, ed);
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    chk(dq_oe_o, 1'b0);
    chk(write_buffer_ready_o, 1'b1);
    chk(sleep_active_o, 1'b1);
    rst_n_i = 1;
    idle(4);
    for (int m = 0; m < 2; m++) begin
      // straps change only while the port sits idle.
      flow_through_select_i = m[0];
      burst_order_select_i = m[0];
      lat = 2 - m;
      b = m ? 17'h1_0040 : 17'h0_0040;
      idle(4);
      // burst write, then masked write and back-to-back read.
      for (int s = 0; s < 4; s++) cmd(0, s != 0, 4'hf, ba(b + 2, s, m[0]), {4'h0, 8'(m), 8'(s), 16'h5A5A}, 1);
      cmd(0, 0, 4'h5, b + 1, 36'h1_2345_6789, 1);
      cmd(1, 0, 4'h0, b + 2, 36'h0, 1);
      idle(4);
      // burst read, then read to write turnaround.
      for (int s = 0; s < 4; s++) cmd(1, s != 0, 4'h0, ba(b + 1, s, m[0]), 36'h0, 1);
      cmd(0, 0, 4'hf, b + 3, 36'hA_BCDE_F012, 1);
      cmd(1, 0, 4'h0, b + 2, 36'h0, 1);
      idle(4);
      cmd(1, 0, 4'h0, b + 3, 36'h0, 1);
      idle(3);
    end
    for (int i = 0; i < 2; i++) begin
      {chip_select_second_i, chip_select_third_n_i} = i ? 2'h3 : 2'h0;
      cmd(1, 0, 4'h0, b, 36'h0, 0);
    end
    {chip_select_second_i, chip_select_third_n_i} = 2'h2;
    clock_enable_n_i = 1;
    cmd(1, 0, 4'h0, b, 36'h0, 0);
    clock_enable_n_i = 0;
    output_enable_n_i = 1;
    cmd(1, 0, 4'h0, b, 36'h0, 1);
    idle(2);
    output_enable_n_i = 0;
    sleep_request_i = 1;
    idle(3);
    chk(sleep_active_o, 1'b1);
    cmd(0, 0, 4'hf, b + 2, 36'h0, 0);
    sleep_request_i = 0;
    idle(3);
    chk(sleep_active_o, 1'b0);
    cmd(1, 0, 4'h0, b + 2, 36'h0, 1);
    idle(4);
    chk(36'(due_q.size()), 36'h0_0000_0000);
    wrap_up();
  end
endmodule : slwsp_sram_port_tb_top
`default_nettype wire
